// file: cal_filter_pkg.sv
// cal_filter_pkg: shared constants for calibration sequencing and filter select
// assumes: classic wishbone slave with 32-bit data, one clock
package cal_filter_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFS     = 8'h00;
	localparam logic [7:0] STATUS_OFFS   = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFFS = 8'h0c;
	localparam logic [7:0] FILTER_OFFS   = 8'h80;
	localparam logic [7:0] OFFSET_OFFS   = 8'h20;
	localparam logic [7:0] GAIN_OFFS     = 8'h40;
	localparam logic [7:0] MEAS_OFFS     = 8'h60;
	localparam logic [7:0] SETUPS        = 8'h08;
	// control register fields
	localparam int MODE_LSB  = 0;
	localparam int SETUP_LSB = 4;
	// filter register fields: divider [10:0], type [19:16]
	localparam int DIV_LSB   = 0;
	localparam int TYPE_LSB  = 16;
	// mode codes
	localparam logic [3:0] MODE_IDLE     = 4'h0;
	localparam logic [3:0] MODE_INT_OFFS = 4'h5;
	localparam logic [3:0] MODE_INT_GAIN = 4'h6;
	localparam logic [3:0] MODE_SYS_OFFS = 4'h7;
	localparam logic [3:0] MODE_SYS_GAIN = 4'h8;
	// filter type codes
	localparam logic [3:0] FILT_SINC4    = 4'h0;
	localparam logic [3:0] FILT_SINC4_AV = 4'h1;
	localparam logic [3:0] FILT_SINC3    = 4'h2;
	localparam logic [3:0] FILT_REJ60    = 4'h3;
	localparam logic [3:0] FILT_SINC3_AV = 4'h4;
	localparam logic [3:0] FILT_POST1    = 4'h5;
	localparam logic [3:0] FILT_POST4    = 4'h8;
	// divider limits and conversion multipliers (main-clock cycles)
	localparam logic [10:0] DIV_MIN      = 11'h001;
	localparam logic [10:0] DIV_SINC4_MAX = 11'h00a;
	localparam logic [10:0] DIV_RESET    = 11'h030;
	localparam logic [19:0] MUL_STD      = 20'h00020;
	localparam logic [19:0] MUL_SINC4_AV = 20'h00160;
	localparam logic [19:0] MUL_SINC3_AV = 20'h00140;
	localparam logic [19:0] POST1_CYC    = 20'h00b80;
	localparam logic [19:0] POST2_CYC    = 20'h00c80;
	localparam logic [19:0] POST3_CYC    = 20'h00f80;
	localparam logic [19:0] POST4_CYC    = 20'h01280;
	// first conversion on a new channel spans the filter's full settling
	localparam logic [2:0]  SETTLE_SINC3 = 3'h3;
	localparam logic [2:0]  SETTLE_SINC4 = 3'h4;
	localparam logic [2:0]  SETTLE_ONE   = 3'h1;
	// reset values of the coefficients
	localparam logic [15:0] OFFSET_RESET = 16'h8000;
	localparam logic [15:0] GAIN_RESET   = 16'h5555;
	// interrupt status bits
	localparam int IRQ_CAL_DONE = 0;
	localparam int IRQ_DIV_CLAMP = 1;
	localparam int IRQ_W        = 2;
endpackage

// file: cal_coef_if.sv
// cal_coef_if: carries a coefficient read and write between control and store
// assumes: both ends on sys_clk_in
`timescale 1ns/1ns
`default_nettype none
interface cal_coef_if;
	logic        wr_en;
	logic [3:0]  wr_addr;
	logic [15:0] wr_data;
	logic [3:0]  rd_addr;
	logic [15:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: cal_coef_mem.sv
// cal_coef_mem: offset and gain coefficients, eight setups each (index 0-7 offset, 8-15 gain)
// assumes: synchronous write, registered read data one cycle after address
`timescale 1ns/1ns
`default_nettype none
module cal_coef_mem (
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	// access port
	cal_coef_if.store       port
);
	logic [15:0] mem_reg  [16];
	logic [15:0] mem_next [16];
	logic [15:0] rd_reg;
	logic [15:0] rd_next;

	// per-entry write; reset puts coefficients at their defaults
	genvar i;
	for (i = 0; i < 16; i++) begin : g_ent
		always_comb begin
			mem_next[i] = mem_reg[i];
			if (port.wr_en && port.wr_addr == 4'(i)) begin
				mem_next[i] = port.wr_data;
			end
		end
		always_ff @(posedge sys_clk_in or posedge rst_in) begin
			if (rst_in) begin
				mem_reg[i] <= (i < 8) ? cal_filter_pkg::OFFSET_RESET : cal_filter_pkg::GAIN_RESET;
			end else begin
				mem_reg[i] <= mem_next[i];
			end
		end
	end

	// read data comes out of a register
	always_comb begin
		rd_next = mem_reg[port.rd_addr];
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_reg <= 16'h0000;
		end else begin
			rd_reg <= rd_next;
		end
	end
	assign port.rd_data = rd_reg;
endmodule
`default_nettype wire

// file: cal_filter_ctrl.sv
// cal_filter_ctrl: calibration sequencing, per-setup filter select, conversion timing
// assumes: classic wishbone slave, front end delivers a 16-bit measurement on meas_valid_in
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cal_filter_ctrl (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// analog front end
	input  wire logic        meas_valid_in,
	input  wire logic [15:0] meas_data_in,
	output logic             positive_input_open_out,
	output logic             tie_positive_to_negative_out,
	output logic             full_scale_ref_out,
	output logic [3:0]       filter_type_out,
	output logic [10:0]      rate_divider_out,
	// status
	output logic             data_ready_out,
	output logic             irq_out
);
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} cal_state_t;

	cal_coef_if coef ();
	cal_coef_mem u_mem (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.port       (coef)
	);

	cal_state_t  state_reg, state_next;
	logic [3:0]  mode_reg, mode_next;
	logic [2:0]  setup_reg, setup_next;
	logic [19:0] cnt_reg, cnt_next;
	logic        pend_reg, pend_next;
	logic [15:0] meas_reg, meas_next;
	logic [3:0]  ftype_reg [8];
	logic [3:0]  ftype_next [8];
	logic [10:0] div_reg [8];
	logic [10:0] div_next [8];
	logic [2:0]  start_setup;
	logic [1:0]  ist_reg, ist_next, imask_reg, imask_next;
	logic        ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic        mvs1_reg, mvs2_reg;
	logic [19:0] conv_cyc;
	logic [10:0] eff_div;
	logic        wb_req, wr_hit, cal_done_ev, clamp_ev;
	logic [2:0]  ws;
	logic        w_filt, w_ctrl;
	logic [2:0]  settle;

	// a clamp is judged on the setup being started, not on the one left over from the last run
	assign start_setup = wb_dat_i[cal_filter_pkg::SETUP_LSB +: 3];
	assign clamp_ev    = w_ctrl && wb_dat_i[cal_filter_pkg::MODE_LSB +: 4] >= cal_filter_pkg::MODE_INT_OFFS
		&& wb_dat_i[cal_filter_pkg::MODE_LSB +: 4] <= cal_filter_pkg::MODE_SYS_GAIN
		&& (ftype_reg[start_setup] == cal_filter_pkg::FILT_SINC4
		|| ftype_reg[start_setup] == cal_filter_pkg::FILT_SINC4_AV)
		&& div_reg[start_setup] > cal_filter_pkg::DIV_SINC4_MAX;

	assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_hit = wb_req && wb_we_i && wb_sel_i[0];
	assign ws     = wb_adr_i[4:2];
	assign w_filt = wr_hit && (wb_adr_i[7:5] == cal_filter_pkg::FILTER_OFFS[7:5]);
	assign w_ctrl = wr_hit && (wb_adr_i == cal_filter_pkg::CTRL_OFFS) && state_reg == ST_IDLE;

	// valid from the front end crosses from the analog side, so it is synchronised
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mvs1_reg <= 1'b0;
			mvs2_reg <= 1'b0;
		end else begin
			mvs1_reg <= meas_valid_in;
			mvs2_reg <= mvs1_reg;
		end
	end

	// per-setup filter fields: sinc3 after reset, a divider write below DIV_MIN is refused
	genvar g;
	for (g = 0; g < 8; g++) begin : g_setup
		always_comb begin
			logic [10:0] d;
			logic [3:0]  t;
			d = wb_dat_i[cal_filter_pkg::DIV_LSB +: 11];
			t = wb_dat_i[cal_filter_pkg::TYPE_LSB +: 4];
			ftype_next[g] = ftype_reg[g];
			div_next[g]   = div_reg[g];
			if (w_filt && ws == 3'(g) && wb_sel_i[2]) begin
				if (t <= cal_filter_pkg::FILT_POST4) begin
					ftype_next[g] = t;
				end
			end
			if (w_filt && ws == 3'(g) && d >= cal_filter_pkg::DIV_MIN) begin
				div_next[g] = d;
			end
		end
		always_ff @(posedge sys_clk_in or posedge rst_in) begin
			if (rst_in) begin
				ftype_reg[g] <= cal_filter_pkg::FILT_SINC3;
				div_reg[g]   <= cal_filter_pkg::DIV_RESET;
			end else begin
				ftype_reg[g] <= ftype_next[g];
				div_reg[g]   <= div_next[g];
			end
		end
	end

	// effective divider and conversion length for the active setup
	always_comb begin
		eff_div  = div_reg[setup_reg];
		conv_cyc = 20'h00000;
		settle   = cal_filter_pkg::SETTLE_ONE;
		case (ftype_reg[setup_reg])
			cal_filter_pkg::FILT_SINC4, cal_filter_pkg::FILT_SINC4_AV: begin
				if (eff_div > cal_filter_pkg::DIV_SINC4_MAX) begin
					eff_div  = cal_filter_pkg::DIV_SINC4_MAX;
				end
			end
			default: begin
			end
		endcase
		case (ftype_reg[setup_reg])
			cal_filter_pkg::FILT_SINC4: begin
				conv_cyc = 20'(cal_filter_pkg::MUL_STD * eff_div);
				settle   = cal_filter_pkg::SETTLE_SINC4;
			end
			cal_filter_pkg::FILT_SINC4_AV: conv_cyc = 20'(cal_filter_pkg::MUL_SINC4_AV * eff_div);
			cal_filter_pkg::FILT_SINC3, cal_filter_pkg::FILT_REJ60: begin
				conv_cyc = 20'(cal_filter_pkg::MUL_STD * eff_div);
				settle   = cal_filter_pkg::SETTLE_SINC3;
			end
			cal_filter_pkg::FILT_SINC3_AV: conv_cyc = 20'(cal_filter_pkg::MUL_SINC3_AV * eff_div);
			4'h5: conv_cyc = cal_filter_pkg::POST1_CYC;
			4'h6: conv_cyc = cal_filter_pkg::POST2_CYC;
			4'h7: conv_cyc = cal_filter_pkg::POST3_CYC;
			default: conv_cyc = cal_filter_pkg::POST4_CYC;
		endcase
	end

	// calibration sequencer
	always_comb begin
		logic [3:0] m;
		m            = wb_dat_i[cal_filter_pkg::MODE_LSB +: 4];
		state_next   = state_reg;
		mode_next    = mode_reg;
		setup_next   = setup_reg;
		cnt_next     = cnt_reg;
		pend_next    = pend_reg;
		meas_next    = meas_reg;
		cal_done_ev  = 1'b0;
		coef.wr_en   = 1'b0;
		coef.wr_addr = {mode_reg == cal_filter_pkg::MODE_INT_GAIN || mode_reg == cal_filter_pkg::MODE_SYS_GAIN,
			setup_reg};
		coef.wr_data = meas_reg;
		if (mvs2_reg) begin
			meas_next = meas_data_in;
		end
		case (state_reg)
			ST_IDLE: begin
				if (w_ctrl && m >= cal_filter_pkg::MODE_INT_OFFS && m <= cal_filter_pkg::MODE_SYS_GAIN) begin
					mode_next  = m;
					setup_next = wb_dat_i[cal_filter_pkg::SETUP_LSB +: 3];
					pend_next  = 1'b1;
					cnt_next   = 20'h00000;
					state_next = ST_CONV;
				end
			end
			ST_CONV: begin
				// one first conversion: filter settling times the settled period
				cnt_next = cnt_reg + 20'h00001;
				if (cnt_reg >= 20'(conv_cyc * settle) - 20'h00001) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				coef.wr_en  = 1'b1;
				pend_next   = 1'b0;
				mode_next   = cal_filter_pkg::MODE_IDLE;
				cal_done_ev = 1'b1;
				state_next  = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			mode_reg  <= cal_filter_pkg::MODE_IDLE;
			setup_reg <= 3'h0;
			cnt_reg   <= 20'h00000;
			pend_reg  <= 1'b0;
			meas_reg  <= 16'h0000;
		end else begin
			state_reg <= state_next;
			mode_reg  <= mode_next;
			setup_reg <= setup_next;
			cnt_reg   <= cnt_next;
			pend_reg  <= pend_next;
			meas_reg  <= meas_next;
		end
	end

	// input routing: internal offset cal shorts the positive input onto the negative one
	assign positive_input_open_out     = mode_reg == cal_filter_pkg::MODE_INT_OFFS;
	assign tie_positive_to_negative_out = mode_reg == cal_filter_pkg::MODE_INT_OFFS;
	assign full_scale_ref_out          = mode_reg == cal_filter_pkg::MODE_INT_GAIN;
	assign filter_type_out             = ftype_reg[setup_reg];
	assign rate_divider_out            = eff_div;
	assign data_ready_out              = pend_reg;

	// interrupt status: set wins over a write-one clear
	always_comb begin
		logic [1:0] ev;
		ev = {clamp_ev, cal_done_ev};
		ist_next   = ist_reg;
		imask_next = imask_reg;
		if (wr_hit && wb_adr_i == cal_filter_pkg::IRQ_STAT_OFFS) begin
			ist_next = ist_reg & ~wb_dat_i[1:0];
		end
		if (wr_hit && wb_adr_i == cal_filter_pkg::IRQ_MASK_OFFS) begin
			imask_next = wb_dat_i[1:0];
		end
		ist_next = ist_next | ev;
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ist_reg   <= 2'h0;
			imask_reg <= 2'h0;
		end else begin
			ist_reg   <= ist_next;
			imask_reg <= imask_next;
		end
	end
	assign irq_out = |(ist_reg & imask_reg);

	// coefficient reads use the registered store port; ack waits one extra cycle for it
	assign coef.rd_addr = {wb_adr_i[5] == 1'b0 && wb_adr_i[6], wb_adr_i[4:2]};
	logic rd_wait_reg, rd_wait_next;
	always_comb begin
		logic coef_hit;
		coef_hit     = wb_adr_i[7:5] == cal_filter_pkg::OFFSET_OFFS[7:5] ||
			wb_adr_i[7:5] == cal_filter_pkg::GAIN_OFFS[7:5];
		ack_next     = 1'b0;
		rd_wait_next = 1'b0;
		rdat_next    = rdat_reg;
		if (wb_req) begin
			if (coef_hit && !wb_we_i && !rd_wait_reg) begin
				rd_wait_next = 1'b1;
			end else begin
				ack_next  = 1'b1;
				rdat_next = 32'h00000000;
				if (coef_hit) begin
					rdat_next = {16'h0000, coef.rd_data};
				end else if (wb_adr_i[7:5] == cal_filter_pkg::FILTER_OFFS[7:5]) begin
					rdat_next = {12'h000, ftype_reg[ws], 5'h00, div_reg[ws]};
				end else begin
					case (wb_adr_i)
						cal_filter_pkg::CTRL_OFFS:     rdat_next = {25'h0, setup_reg, mode_reg};
						cal_filter_pkg::STATUS_OFFS:   rdat_next = {30'h0, state_reg != ST_IDLE, pend_reg};
						cal_filter_pkg::IRQ_STAT_OFFS: rdat_next = {30'h0, ist_reg};
						cal_filter_pkg::IRQ_MASK_OFFS: rdat_next = {30'h0, imask_reg};
						cal_filter_pkg::MEAS_OFFS:     rdat_next = {16'h0, meas_reg};
						default:                       rdat_next = 32'h00000000;
					endcase
				end
			end
		end
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_reg     <= 1'b0;
			rd_wait_reg <= 1'b0;
			rdat_reg    <= 32'h00000000;
		end else begin
			ack_reg     <= ack_next;
			rd_wait_reg <= rd_wait_next;
			rdat_reg    <= rdat_next;
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
endmodule
`default_nettype wire

// file: cal_filter_props.sv
// cal_filter_props: concurrent checks on the top ports of cal_filter_ctrl
// assumes: one clock, rst_in async active high; bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module cal_filter_props (
	// clock and reset
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	// front end and status
	input wire logic        positive_input_open_out,
	input wire logic        tie_positive_to_negative_out,
	input wire logic        full_scale_ref_out,
	input wire logic [3:0]  filter_type_out,
	input wire logic [10:0] rate_divider_out,
	input wire logic        data_ready_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	logic [19:0] len_reg;
	logic [19:0] len_next;
	logic [19:0] want;
	// length of the pending phase; filter outputs hold during a calibration unless that setup's filter register is written, so want is read at its end
	always_comb begin
		len_next = data_ready_out ? len_reg + 20'h00001 : 20'h00000;
		want = (filter_type_out == cal_filter_pkg::FILT_SINC4 ? 20'h00080 : 20'h00060) * 20'(rate_divider_out);
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			len_reg <= 20'h00000;
		else
			len_reg <= len_next;
	end
	sequence cal_write_s;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h00
			&& wb_dat_i[3:0] inside {[4'h5:4'h8]} && !data_ready_out;
	endsequence
	sequence cal_end_s;
		$fell(data_ready_out);
	endsequence
	chk_ready_on_start: assert property (cal_write_s |-> ##[1:2] data_ready_out)
		else $error("calibration start did not raise data ready");
	chk_cal_length: assert property ($fell(data_ready_out) && filter_type_out inside {4'h0, 4'h2}
		|-> len_reg + 20'h00002 >= want && len_reg <= want + 20'h00002)
		else $error("calibration length differs from one first conversion");
	chk_idle_after_cal: assert property (cal_end_s |-> ##1 !positive_input_open_out && !full_scale_ref_out)
		else $error("routing not idle after calibration end");
	chk_tie_pair: assert property (positive_input_open_out == tie_positive_to_negative_out)
		else $error("positive input open and tie disagree");
	chk_mode_exclusive: assert property (full_scale_ref_out |-> !positive_input_open_out)
		else $error("offset and gain routing both active");
	chk_reset_sinc3: assert property ($past(rst_in) |-> filter_type_out == cal_filter_pkg::FILT_SINC3)
		else $error("filter after reset is not third-order sinc");
	chk_sinc4_range: assert property (filter_type_out == 4'h0 |-> rate_divider_out inside {[11'h001:11'h00a]})
		else $error("fourth-order sinc divider outside 1 to 10");
	chk_div_nonzero: assert property (rate_divider_out != 11'h000)
		else $error("divider of zero applied");
endmodule
bind cal_filter_ctrl cal_filter_props u_props (.sys_clk_in, .rst_in, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_ack_o, .positive_input_open_out, .tie_positive_to_negative_out,
	.full_scale_ref_out, .filter_type_out, .rate_divider_out, .data_ready_out);
`default_nettype wire

// file: front_end_model.sv
// front_end_model: stands in for the analog front end and modulator
// assumes: routing controls from cal_filter_ctrl, external level set by the bench
`timescale 1ns/1ns
`default_nettype none
module front_end_model #(
	parameter logic [15:0] ZERO_CODE = 16'h0011,
	parameter logic [15:0] FULL_CODE = 16'h7e0f
) (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// routing and external level
	input  wire logic        positive_input_open_in,
	input  wire logic        tie_positive_to_negative_in,
	input  wire logic        full_scale_ref_in,
	input  wire logic [15:0] level_in,
	// measurement stream
	output logic             meas_valid_out,
	output logic      [15:0] meas_data_out
);
	logic [2:0]  tick_reg;
	logic [15:0] held;
	// opened and tied positive input measures a zero differential
	always_comb begin
		if (positive_input_open_in && tie_positive_to_negative_in)
			held = ZERO_CODE;
		else if (full_scale_ref_in)
			held = FULL_CODE;
		else
			held = level_in;
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			tick_reg <= 3'h0;
		else
			tick_reg <= tick_reg + 3'h1;
	end
	// data outlives valid by three cycles for the receiver's synchroniser, then shows garbage
	assign meas_valid_out = tick_reg[2:1] == 2'h0;
	assign meas_data_out = tick_reg < 3'h5 ? held : ~held;
endmodule
`default_nettype wire

// file: testbench.sv
// testbench: drives cal_filter_ctrl over wishbone with a front end model attached
// assumes: cal_filter_pkg compiled first, checker bound from its own file
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [15:0] ZC = 16'h0011;
	localparam logic [15:0] FC = 16'h7e0f;
	logic        sys_clk_in, rst_in, cyc, stb, we, valid, open_p, tie, fsref, ready, irq, ack;
	logic [7:0]  adr;
	logic [3:0]  sel, wsel;
	logic [31:0] wdat, rdat;
	logic [15:0] meas, level;
	logic [3:0]  ftype;
	logic [10:0] div;
	int          err_count, samples_checked;

	cal_filter_ctrl u_dut (.sys_clk_in, .rst_in, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .meas_valid_in(valid),
		.meas_data_in(meas), .positive_input_open_out(open_p), .tie_positive_to_negative_out(tie),
		.full_scale_ref_out(fsref), .filter_type_out(ftype), .rate_divider_out(div), .data_ready_out(ready),
		.irq_out(irq));
	front_end_model #(.ZERO_CODE(ZC), .FULL_CODE(FC)) u_fe (.sys_clk_in, .rst_in, .positive_input_open_in(open_p),
		.tie_positive_to_negative_in(tie), .full_scale_ref_in(fsref), .level_in(level), .meas_valid_out(valid),
		.meas_data_out(meas));

	// 25 MHz main clock
	initial begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
		samples_checked++;
		if (seen !== exp_v) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp_v);
		end
	endtask
	// one classic cycle; held until ack is sampled, never assumes the answer latency
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= wsel;
		wdat <= d;
		// only the watchdog ends a wait that never sees ack
		do begin
			@(posedge sys_clk_in);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_v);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp_v);
	endtask
	task automatic irq_chk(input logic exp_v);
		@(posedge sys_clk_in);
		check(32'(irq), 32'(exp_v));
	endtask
	// start a calibration, judge routing and filter while it runs, then its length
	task automatic run_cal(input logic [2:0] s, input logic [3:0] m, input logic [3:0] t, input logic [10:0] d);
		int n, want;
		// sinc4 settles over four periods, sinc3 over three; post filter 1 has a fixed period
		want = (t == 4'h0) ? 128 * d : (t == 4'h2) ? 96 * d : 2944;
		wr(8'h00, {25'h0, s, m});
		check(32'({ftype, div, open_p, tie, fsref}), 32'({t, d, m == 4'h5, m == 4'h5, m == 4'h6}));
		rd_chk(8'h04, 32'h3);
		n = 3; // the status read above spans three cycles of the calibration
		while (ready !== 1'b0 && n < 4000) begin
			@(posedge sys_clk_in);
			n++;
		end
		check(32'(n >= want - 2 && n <= want + 3), 32'h1);
		rd_chk(8'h00, 32'({s, 4'h0}));
		rd_chk(8'h04, 32'h0);
	endtask
	task automatic t_defaults;
		rd_chk(8'h80, 32'h0002_0030);
		rd_chk(8'h20, 32'h8000);
		rd_chk(8'h40, 32'h5555);
		rd_chk(8'hfc, 32'h0);
	endtask
	// refused divider, type write gated by its byte select, then a clamped fourth-order sinc setup
	task automatic t_filters;
		wr(8'h88, 32'h0002_0000);
		rd_chk(8'h88, 32'h0002_0030);
		wsel = 4'h1;
		wr(8'h88, 32'h0000_0021);
		wsel = 4'hf;
		rd_chk(8'h88, 32'h0002_0021);
		wr(8'h00, 32'h0000_0009);
		irq_chk(1'b0);
		check(32'(ready), 32'h0);
		wr(8'h84, 32'h0000_0020);
		run_cal(3'h1, 4'h6, 4'h0, 11'h00a);
		rd_chk(8'h44, 32'(FC));
	endtask
	task automatic t_irq;
		rd_chk(8'h08, 32'h3);
		irq_chk(1'b0);
		wr(8'h0c, 32'h2);
		irq_chk(1'b1);
		wr(8'h08, 32'h2);
		irq_chk(1'b0);
		wr(8'h0c, 32'h1);
		irq_chk(1'b1);
		wr(8'h08, 32'h1);
		irq_chk(1'b0);
		rd_chk(8'h08, 32'h0);
	endtask
	// full sequence on setup 0: internal gain, internal offset, then system offset and gain
	task automatic t_cals;
		wr(8'h80, 32'h0002_0001);
		run_cal(3'h0, 4'h6, 4'h2, 11'h001);
		rd_chk(8'h40, 32'(FC));
		run_cal(3'h0, 4'h5, 4'h2, 11'h001);
		rd_chk(8'h20, 32'(ZC));
		level <= 16'h0123;
		run_cal(3'h0, 4'h7, 4'h2, 11'h001);
		rd_chk(8'h20, 32'h0123);
		level <= 16'h6abc;
		run_cal(3'h0, 4'h8, 4'h2, 11'h001);
		rd_chk(8'h40, 32'h6abc);
		rd_chk(8'h60, 32'h6abc);
		// post filter 1 on setup 3: length must not follow the divider
		wr(8'h8c, 32'h0005_0001);
		run_cal(3'h3, 4'h7, 4'h5, 11'h001);
		rd_chk(8'h2c, 32'h6abc);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		err_count = 0;
		samples_checked = 0;
		rst_in = 1'b1;
		{cyc, stb, we, adr, sel, wdat, level} = '0;
		wsel = 4'hf;
		repeat (3) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_defaults;
		t_filters;
		t_irq;
		t_cals;
		finish_test;
	end
	// all scenarios need under 6000 cycles; this limit leaves wide margin
	initial begin
		#(20000 * 40);
		err_count++;
		finish_test;
	end
endmodule
`default_nettype wire
